// ===== rtl/reset_irq_vector_map.sv
`timescale 1ns/1ps
// What this block does
// [R1] unprogrammed fuse: reset jumps to zero
// [R2] programmed fuse: reset jumps to boot start
// [R3] fuse value 1 unprogrammed, 0 programmed
// [R4] select set: vectors offset by boot start
// [R5] table starts at 0x0002 or boot+0x0002
// [R6] external_irq_zero, pin change zero, one at 2,4,6
// [R7] second 8-bit timer: 0x0008, 0x000A
// [R8] 16-bit timer: 0x000C through 0x0012
// [R9] first 8-bit timer: 0x0014, 0x0016
// [R10] serial peripheral complete at 0x0018
// [R11] usart events at 0x001A, 0x001C, 0x001E
// [R12] serial iface start, overflow: 0x0020, 0x0022
// [R13] comparator 0x0024, converter 0x0026
// [R14] eeprom, store, lcd at 0x0028..0x002C
// [R15] change enable clears after four cycles
// [R16] interrupts blocked during change sequence
// [R17] vector is base plus twice source index
module reset_irq_vector_map (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic ce, // clock enable, freezes state when low
    input wire logic boot_reset_select_fuse, // fuse, 1 = unprogrammed
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic vec_req, // core asks for a vector
    input wire logic vec_is_reset, // request is the reset target
    input wire logic [4:0] vec_src, // zero-based interrupt source
    output logic vec_valid, // answer valid, one cycle
    output logic [15:0] vec_addr, // answered program address
    output logic irq_block // interrupts blocked
);
    vec_req_if vbus ();
    logic acc;
    logic wr;
    logic hit_ctrl;
    logic hit_boot;
    logic hit_stat;
    logic chg_wr;
    logic sel_wr;
    logic chg;
    logic sel;
    logic block;
    logic [15:0] boot_q;
    logic [31:0] rd_d;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic block_q;
    logic [2:0] fuse_sync_q;
    logic fuse_q;
    logic fuse_agree;

    assign acc = psel && penable && !pready_q;
    assign wr = acc && pwrite;
    assign hit_ctrl = paddr == vector_map_pkg::CTRL_ADDR;
    assign hit_boot = paddr == vector_map_pkg::BOOT_ADDR;
    assign hit_stat = paddr == vector_map_pkg::STATUS_ADDR;
    assign chg_wr = wr && hit_ctrl && pwdata[vector_map_pkg::CHG_BIT]; // [R15]
    assign sel_wr = wr && hit_ctrl && !pwdata[vector_map_pkg::CHG_BIT];

    assign rd_d = hit_ctrl ? {30'h0, sel, chg}
        : hit_boot ? {16'h0, boot_q}
        : hit_stat ? {28'h0, fuse_q, block, chg, sel}
        : 32'h0;

    vector_change_guard u_guard (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .chg_wr(chg_wr),
        .sel_wr(sel_wr),
        .sel_val(pwdata[vector_map_pkg::SEL_BIT]),
        .chg_q(chg),
        .sel_q(sel),
        .block_q(block)
    );

    assign vbus.req = vec_req;
    assign vbus.is_reset = vec_is_reset;
    assign vbus.src = vec_src;

    // fuse level is not timed to pclk; a change counts once stages two and three agree
    assign fuse_agree = fuse_sync_q[1] == fuse_sync_q[2];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fuse_sync_q <= {3{vector_map_pkg::FUSE_UNPROGRAMMED}};
            fuse_q <= vector_map_pkg::FUSE_UNPROGRAMMED;
        end else if (ce) begin
            fuse_sync_q <= {fuse_sync_q[1:0], boot_reset_select_fuse};
            if (fuse_agree) begin
                fuse_q <= fuse_sync_q[2]; // [R3]
            end
        end
    end

    vector_addr_calc u_calc (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .fuse_unprog(fuse_q),
        .table_sel(sel),
        .boot_start(boot_q),
        .bus(vbus)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_q <= vector_map_pkg::BOOT_START_DEFAULT;
            prdata_q <= 32'h0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            block_q <= 1'b0;
        end else if (ce) begin
            pready_q <= acc;
            pslverr_q <= acc && !(hit_ctrl || hit_boot || hit_stat);
            if (acc && !pwrite) begin
                prdata_q <= rd_d;
            end
            if (wr && hit_boot) begin
                boot_q <= pwdata[15:0];
            end
            block_q <= block; // [R16]
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign vec_valid = vbus.valid;
    assign vec_addr = vbus.addr;
    assign irq_block = block_q;
endmodule // reset_irq_vector_map

// ===== rtl/vector_map_pkg.sv
package vector_map_pkg;
    // program address width in words
    localparam int ADDR_W = 16;
    localparam int SRC_W = 5;
    localparam logic [4:0] NUM_SRC = 5'h16;
    localparam logic [15:0] RESET_ADDR_APP = 16'h0000;
    localparam logic [15:0] TABLE_OFFSET = 16'h0002;
    localparam logic [15:0] BOOT_START_DEFAULT = 16'h1C00;
    // vector-change window length in clock cycles
    localparam logic [2:0] CHANGE_WINDOW = 3'h4;
    // blocking lasts one more instruction after the select write
    localparam logic [2:0] POST_WRITE_HOLD = 3'h2;
    // apb register byte addresses
    localparam logic [11:0] CTRL_ADDR = 12'h000;
    localparam logic [11:0] BOOT_ADDR = 12'h004;
    localparam logic [11:0] STATUS_ADDR = 12'h008;
    // control register bit positions
    localparam int SEL_BIT = 1;
    localparam int CHG_BIT = 0;
    // status register bit positions
    localparam int ST_SEL_BIT = 0;
    localparam int ST_CHG_BIT = 1;
    localparam int ST_BLOCK_BIT = 2;
    localparam int ST_FUSE_BIT = 3;
    // fuse stored value meaning unprogrammed
    localparam logic FUSE_UNPROGRAMMED = 1'b1;
endpackage

// ===== rtl/vec_req_if.sv
`timescale 1ns/1ps
interface vec_req_if;
    logic req;
    logic is_reset;
    logic [vector_map_pkg::SRC_W-1:0] src;
    logic valid;
    logic [vector_map_pkg::ADDR_W-1:0] addr;
    modport core (output req, is_reset, src, input valid, addr);
    modport calc (input req, is_reset, src, output valid, addr);
endinterface

// ===== rtl/vector_addr_calc.sv
`timescale 1ns/1ps
module vector_addr_calc (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic ce, // clock enable
    input wire logic fuse_unprog, // boot reset fuse, 1 = unprogrammed
    input wire logic table_sel, // vector table in boot section
    input wire logic [vector_map_pkg::ADDR_W-1:0] boot_start, // boot section start
    vec_req_if.calc bus // vector request and answer
);
    logic [vector_map_pkg::ADDR_W-1:0] table_base;
    logic [vector_map_pkg::ADDR_W-1:0] reset_target;
    logic [vector_map_pkg::ADDR_W-1:0] vec_addr;
    logic [vector_map_pkg::ADDR_W-1:0] slot_off;
    logic src_ok;
    logic valid_q;
    logic [vector_map_pkg::ADDR_W-1:0] addr_q;

    assign reset_target = (fuse_unprog == vector_map_pkg::FUSE_UNPROGRAMMED)
        ? vector_map_pkg::RESET_ADDR_APP : boot_start; // [R1] [R2] [R3]
    assign table_base = (table_sel ? boot_start : '0)
        + vector_map_pkg::TABLE_OFFSET; // [R4] [R5]
    assign src_ok = bus.src < vector_map_pkg::NUM_SRC;
    // slots of two words in table order, sources 0..21
    assign slot_off = {{(vector_map_pkg::ADDR_W-vector_map_pkg::SRC_W-1){1'b0}},
        bus.src, 1'b0}; // [R17]
    assign vec_addr = table_base + slot_off; // [R6] [R7] [R8] [R9] [R10] [R11] [R12] [R13] [R14]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid_q <= 1'b0;
            addr_q <= '0;
        end else if (ce) begin
            valid_q <= bus.req && (bus.is_reset || src_ok);
            // the answered address stands until the next request
            if (bus.req) begin
                addr_q <= bus.is_reset ? reset_target : vec_addr;
            end
        end
    end

    assign bus.valid = valid_q;
    assign bus.addr = addr_q;
endmodule // vector_addr_calc

// ===== rtl/vector_change_guard.sv
`timescale 1ns/1ps
module vector_change_guard (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic ce, // clock enable
    input wire logic chg_wr, // write with change-enable bit set
    input wire logic sel_wr, // write with change-enable bit clear
    input wire logic sel_val, // value written to table select
    output logic chg_q, // change enable state
    output logic sel_q, // table select state
    output logic block_q // interrupts blocked
);
    logic [2:0] win_q;
    logic [2:0] hold_q;
    logic sel_accept;

    assign sel_accept = sel_wr && chg_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chg_q <= 1'b0;
            sel_q <= 1'b0;
            win_q <= '0;
            hold_q <= '0;
        end else if (ce) begin
            if (chg_wr) begin
                chg_q <= 1'b1;
                win_q <= vector_map_pkg::CHANGE_WINDOW;
            end else if (sel_accept || win_q == 3'h1) begin
                chg_q <= 1'b0; // [R15]
                win_q <= '0;
            end else if (win_q != '0) begin
                win_q <= win_q - 3'h1;
            end
            if (sel_accept) begin
                sel_q <= sel_val; // [R15]
                hold_q <= vector_map_pkg::POST_WRITE_HOLD;
            end else if (hold_q != '0) begin
                hold_q <= hold_q - 3'h1;
            end
        end
    end

    // blocks in the set cycle itself and through the post-write instruction
    assign block_q = chg_wr || chg_q || hold_q != '0; // [R16]
endmodule // vector_change_guard

// ===== tb/reset_irq_vector_map_properties.sv
`timescale 1ns/1ps
module vector_map_checker (
    input wire logic pclk, // clock
    input wire logic presetn, // reset
    input wire logic boot_reset_select_fuse, // fuse
    input wire logic psel, // apb
    input wire logic penable, // apb
    input wire logic pwrite, // apb
    input wire logic [11:0] paddr, // apb
    input wire logic [31:0] pwdata, // apb
    input wire logic pready, // apb
    input wire logic pslverr, // apb
    input wire logic vec_req, // request
    input wire logic vec_is_reset, // request
    input wire logic [4:0] vec_src, // request
    input wire logic vec_valid, // answer
    input wire logic [15:0] vec_addr, // answer
    input wire logic irq_block // block
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [15:0] boot_q;
    wire wr_acc = psel && penable && pready && pwrite;
    wire mapped = paddr inside {12'h000, 12'h004, 12'h008};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) boot_q <= vector_map_pkg::BOOT_START_DEFAULT;
        else if (wr_acc && paddr == vector_map_pkg::BOOT_ADDR) boot_q <= pwdata[15:0];
    end
    // the design sees a fuse change only after its synchroniser has settled
    logic [3:0] fuse_hist_q;
    wire fuse_settled = fuse_hist_q == {4{boot_reset_select_fuse}};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) fuse_hist_q <= 4'hF;
        else fuse_hist_q <= {fuse_hist_q[2:0], boot_reset_select_fuse};
    end
    sequence s_arm;
        wr_acc && paddr == vector_map_pkg::CTRL_ADDR && pwdata[0];
    endsequence
    property p_rst_zero;
        vec_req && vec_is_reset && boot_reset_select_fuse && fuse_settled
            |=> vec_valid && vec_addr == 16'h0000;
    endproperty
    property p_rst_boot;
        vec_req && vec_is_reset && !boot_reset_select_fuse && fuse_settled
            |=> vec_valid && vec_addr == boot_q;
    endproperty
    property p_answer;
        vec_req && (vec_is_reset || vec_src < 5'h16) |=> vec_valid;
    endproperty
    property p_refuse;
        vec_req && !vec_is_reset && vec_src >= 5'h16 |=> !vec_valid;
    endproperty
    property p_access;
        psel && penable && !pready |=> pready;
    endproperty
    property p_err;
        pready |-> pslverr == !mapped;
    endproperty
    property p_block_on;
        s_arm |-> ##[1:2] irq_block ##1 irq_block;
    endproperty
    property p_block_off;
        s_arm ##1 !(psel && pwrite) [*6] |-> !irq_block;
    endproperty
    a_rst_zero: assert property (p_rst_zero) else $error("reset target not zero");
    a_rst_boot: assert property (p_rst_boot) else $error("reset target not boot");
    a_answer: assert property (p_answer) else $error("no vector answer");
    a_refuse: assert property (p_refuse) else $error("bad source answered");
    a_access: assert property (p_access) else $error("apb access too long");
    a_err: assert property (p_err) else $error("apb error flag wrong");
    a_block_on: assert property (p_block_on) else $error("block missing");
    a_block_off: assert property (p_block_off) else $error("block stuck");
endmodule // vector_map_checker
bind reset_irq_vector_map vector_map_checker CHK (.pclk, .presetn, .boot_reset_select_fuse,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .vec_req, .vec_is_reset,
    .vec_src, .vec_valid, .vec_addr, .irq_block);

// ===== tb/vec_core_model.sv
`timescale 1ns/1ps
module vec_core_model (
    input wire logic pclk, // clock
    input wire logic vec_valid, // answer strobe
    output logic vec_req, // request
    output logic vec_is_reset, // reset target wanted
    output logic [4:0] vec_src // source index
);
    initial begin
        vec_req = 1'b0;
        vec_is_reset = 1'b0;
        vec_src = 5'h00;
    end
    // one request; answer is read once the taking edge has settled
    task automatic ask(input logic rst, input logic [4:0] s, output logic ok);
        @(posedge pclk);
        vec_req <= 1'b1;
        vec_is_reset <= rst;
        vec_src <= s;
        @(posedge pclk);
        vec_req <= 1'b0;
        vec_src <= ~s; // unqualified index shows garbage
        #1 ok = vec_valid;
    endtask
endmodule // vec_core_model

// ===== tb/reset_irq_vector_map_test.sv
`timescale 1ns/1ps
module reset_irq_vector_map_test;
    logic pclk, presetn, fuse, psel, penable, pwrite, pready, pslverr, vec_req, vec_is_reset;
    logic vec_valid, irq_block, ok;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [4:0] vec_src;
    logic [15:0] vec_addr;
    int err_total = 0, n_tests = 0, cyc = 0;
    reset_irq_vector_map DUT (.pclk, .presetn, .ce(1'b1), .boot_reset_select_fuse(fuse), .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .vec_req, .vec_is_reset,
        .vec_src, .vec_valid, .vec_addr, .irq_block);
    vec_core_model CORE (.pclk, .vec_valid, .vec_req, .vec_is_reset, .vec_src);
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task automatic complete_run;
        $display("errors %0d checks %0d", err_total, n_tests);
        if (err_total == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            complete_run;
        end
    end
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        chk({pready, pslverr, 31'h0}, {1'b1, a > 12'h008, 31'h0});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic t_regs;
        apb(1'b0, vector_map_pkg::STATUS_ADDR, 32'h0);
        chk(rdat, 32'h8);
        apb(1'b0, vector_map_pkg::BOOT_ADDR, 32'h0);
        chk(rdat, 32'h1C00);
        apb(1'b0, 12'h00C, 32'h0);
        chk(rdat, 32'h0);
    endtask
    task automatic t_table(input logic [15:0] base);
        logic [15:0] ea;
        for (int s = 0; s < 23; s++) begin
            CORE.ask(1'b0, 5'(s), ok);
            ea = base + 16'h0002 + 16'(2 * s);
            if (s < 22) begin
                chk({ok, vec_addr}, {1'b1, ea});
            end else begin
                chk(ok, 1'b0);
            end
        end
    endtask
    task automatic t_reset;
        CORE.ask(1'b1, 5'h00, ok);
        chk({ok, vec_addr}, 17'h10000);
        fuse <= 1'b0;
        apb(1'b1, vector_map_pkg::BOOT_ADDR, 32'h2000);
        CORE.ask(1'b1, 5'h00, ok);
        chk({ok, vec_addr}, 17'h12000);
    endtask
    task automatic t_move;
        apb(1'b1, vector_map_pkg::CTRL_ADDR, 32'h1);
        chk(irq_block, 1'b1);
        apb(1'b1, vector_map_pkg::CTRL_ADDR, 32'h2);
        apb(1'b0, vector_map_pkg::STATUS_ADDR, 32'h0);
        chk(rdat, 32'h1);
        t_table(16'h2000);
    endtask
    task automatic t_late;
        apb(1'b1, vector_map_pkg::CTRL_ADDR, 32'h1);
        repeat (8) @(posedge pclk);
        apb(1'b1, vector_map_pkg::CTRL_ADDR, 32'h0);
        apb(1'b0, vector_map_pkg::STATUS_ADDR, 32'h0);
        chk(rdat, 32'h1);
        chk(irq_block, 1'b0);
    endtask
    task automatic t_rst;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // the fuse synchroniser settles during this first read
        apb(1'b0, vector_map_pkg::BOOT_ADDR, 32'h0);
        chk(rdat, {16'h0, vector_map_pkg::BOOT_START_DEFAULT});
        apb(1'b0, vector_map_pkg::STATUS_ADDR, 32'h0);
        chk(rdat, 32'h0);
        CORE.ask(1'b1, 5'h00, ok);
        chk({ok, vec_addr}, {1'b1, vector_map_pkg::BOOT_START_DEFAULT});
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        fuse = 1'b1;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_table(16'h0000);
        t_reset;
        t_move;
        t_late;
        t_rst;
        complete_run;
    end
endmodule // reset_irq_vector_map_test
